//--- core/ufsr_core.sv
/*
 * FIFO status, fill levels and software reset of a serial controller.
 * Occupancy is tracked here from push and pop strobes of the data path;
 * assumes data path strobes are on the same clock and respect the flags.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ufsr_core #(
	parameter int unsigned depth = ufsr_pkg::ufsr_fifo_depth
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ufsr_pkg::ufsr_addr_w-1:0] addr,
	input wire logic [ufsr_pkg::ufsr_data_w-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [ufsr_pkg::ufsr_data_w-1:0] rdata,
	input wire logic tx_push,
	input wire logic tx_pop,
	input wire logic rx_push,
	input wire logic rx_pop,
	output logic tx_fifo_flush,
	output logic rx_fifo_flush,
	output logic controller_soft_reset,
	output logic fifo_enable,
	output logic irq
);
	import ufsr_pkg::*;

	typedef struct packed {
		logic [15:0] tx_count;
		logic [15:0] rx_count;
		logic [15:0] rdata;
		logic [15:0] fifo_control_register;
		logic [ufsr_irq_w-1:0] irq_status;
		logic [ufsr_irq_w-1:0] irq_mask;
		logic tx_flush;
		logic rx_flush;
		logic soft_rst;
		logic irq;
		ufsr_rst_state_t rst_state;
		logic [1:0] rst_cnt;
	} ufsr_state_t;

	ufsr_state_t cur;
	ufsr_state_t next_cur;

	localparam logic [15:0] depth_w = 16'(depth);

	function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
		return a == off;
	endfunction : hit

	function automatic logic [15:0] step(input logic [15:0] cnt, input logic up, input logic dn,
		input logic flush);
		logic [15:0] r;
		r = cnt;
		if (flush) begin
			r = 16'h0000;
		end else if (up && !dn && cnt < depth_w) begin
			r = cnt + 16'h0001;
		end else if (dn && !up && cnt != 16'h0000) begin
			r = cnt - 16'h0001;
		end
		return r;
	endfunction : step

	logic [15:0] status_now;
	logic wr_srr;
	logic wr_fcr;
	logic do_tx_flush;
	logic do_rx_flush;
	logic [ufsr_irq_w-1:0] events;
	logic tx_empty_now;

	always_comb begin
		status_now = 16'h0000;
		status_now[ufsr_bit_rx_full] = cur.rx_count == depth_w;
		status_now[ufsr_bit_rx_not_empty] = cur.rx_count != 16'h0000;
		status_now[ufsr_bit_tx_empty] = cur.tx_count == 16'h0000;
		status_now[ufsr_bit_tx_not_full] = cur.tx_count != depth_w;
		status_now = status_now & ufsr_status_mask;
	end

	always_comb begin
		next_cur = cur;
		wr_srr = wr && hit(addr, ufsr_off_soft_reset);
		wr_fcr = wr && hit(addr, ufsr_off_fifo_control);
		// either register flushes the same pointers
		do_tx_flush = (wr_srr || wr_fcr) && wdata[ufsr_bit_tx_flush];
		do_rx_flush = (wr_srr || wr_fcr) && wdata[ufsr_bit_rx_flush];
		tx_empty_now = cur.tx_count == 16'h0001 && tx_pop && !tx_push;
		events = '0;
		events[0] = cur.rx_count == 16'h0000 && rx_push && !do_rx_flush;
		events[1] = cur.rx_count == depth_w - 16'h0001 && rx_push && !rx_pop && !do_rx_flush;
		events[2] = tx_empty_now && !do_tx_flush;
		events[3] = tx_push && !tx_pop && cur.tx_count == depth_w;
		events[4] = rx_push && !rx_pop && cur.rx_count == depth_w;

		next_cur.tx_count = step(cur.tx_count, tx_push, tx_pop, do_tx_flush);
		next_cur.rx_count = step(cur.rx_count, rx_push, rx_pop, do_rx_flush);

		// one-cycle pulses; nothing is stored, so they self-clear
		next_cur.tx_flush = do_tx_flush;
		next_cur.rx_flush = do_rx_flush;
		if (wr_fcr) begin
			// flush bits never stick in the control image
			next_cur.fifo_control_register = wdata & ufsr_fcr_keep_mask;
		end

		if (wr && hit(addr, ufsr_off_irq_mask)) begin
			next_cur.irq_mask = wdata[ufsr_irq_w-1:0];
		end
		next_cur.irq_status = cur.irq_status;
		if (wr && hit(addr, ufsr_off_irq_status)) begin
			next_cur.irq_status = cur.irq_status & ~wdata[ufsr_irq_w-1:0];
		end
		// set beats a simultaneous clear
		next_cur.irq_status = next_cur.irq_status | events;
		next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);

		next_cur.rdata = 16'h0000;
		if (rd) begin
			if (hit(addr, ufsr_off_status)) begin
				next_cur.rdata = status_now;
			end else if (hit(addr, ufsr_off_tx_level)) begin
				next_cur.rdata = cur.tx_count;
			end else if (hit(addr, ufsr_off_rx_level)) begin
				next_cur.rdata = cur.rx_count;
			end else if (hit(addr, ufsr_off_fifo_control)) begin
				next_cur.rdata = cur.fifo_control_register;
			end else if (hit(addr, ufsr_off_irq_status)) begin
				next_cur.rdata = 16'(cur.irq_status);
			end else if (hit(addr, ufsr_off_irq_mask)) begin
				next_cur.rdata = 16'(cur.irq_mask);
			end
			// write-only reset register and unmapped reads return zero
		end

		// soft reset: registered, so asserted on the clock edge that takes the write, held two cycles, then released on the clock
		case (cur.rst_state)
			ufsr_run_s: begin
				next_cur.soft_rst = 1'b0;
				if (wr_srr && wdata[ufsr_bit_soft_reset]) begin
					next_cur.soft_rst = 1'b1;
					next_cur.rst_state = ufsr_hold_s;
					// release cycle still drives the reset, so the hold state runs one cycle short
					next_cur.rst_cnt = 2'(ufsr_rst_hold - 2);
				end
			end
			ufsr_hold_s: begin
				next_cur.soft_rst = 1'b1;
				if (cur.rst_cnt == 2'h0) begin
					next_cur.rst_state = ufsr_release_s;
				end else begin
					next_cur.rst_cnt = cur.rst_cnt - 2'h1;
				end
			end
			ufsr_release_s: begin
				next_cur.soft_rst = 1'b0;
				next_cur.rst_state = ufsr_run_s;
			end
			default: begin
				next_cur.soft_rst = 1'b0;
				next_cur.rst_state = ufsr_run_s;
			end
		endcase

		// the whole controller, this block's FIFO view included, restarts
		if (cur.soft_rst) begin
			next_cur.tx_count = ufsr_level_reset;
			next_cur.rx_count = ufsr_level_reset;
			next_cur.fifo_control_register = 16'h0000;
			next_cur.irq_status = '0;
			next_cur.irq_mask = '0;
			next_cur.irq = 1'b0;
			next_cur.tx_flush = 1'b0;
			next_cur.rx_flush = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cur <= '{tx_count: ufsr_level_reset, rx_count: ufsr_level_reset, rdata: 16'h0000,
				fifo_control_register: 16'h0000, irq_status: '0, irq_mask: '0, tx_flush: 1'b0, rx_flush: 1'b0,
				soft_rst: 1'b0, irq: 1'b0, rst_state: ufsr_run_s, rst_cnt: 2'h0};
		end else begin
			cur <= next_cur;
		end
	end

	assign rdata = cur.rdata;
	assign tx_fifo_flush = cur.tx_flush;
	assign rx_fifo_flush = cur.rx_flush;
	// one reset line feeds both the bus and serial domains of the controller
	assign controller_soft_reset = cur.soft_rst;
	assign fifo_enable = cur.fifo_control_register[ufsr_bit_fifo_enable];
	assign irq = cur.irq;
endmodule : ufsr_core
`default_nettype wire

//--- inc/ufsr_pkg.sv
/*
 * Package for the serial-port FIFO status and soft-reset block.
 * Holds the register map, field positions, reset values and state codes.
 * Assumes the core and the bench both import it; no other surroundings.
 */
// Behaviour
// - Status bit 4 reads one exactly while the receive FIFO is full.
// - Status bit 3 reads one while the receive FIFO holds at least one entry.
// - Status bit 2 reads one while the transmit FIFO is empty, and is one after reset.
// - Status bit 1 reads one while the transmit FIFO has room, and is one after reset.
// - A 16-bit read-only register gives the transmit FIFO entry count, zero after reset.
// - A 16-bit read-only register gives the receive FIFO entry count, zero after reset.
// - Writing one to reset-register bit 2 empties the transmit FIFO pointers.
// - That transmit flush does the same as the FIFO-control transmit reset bit.
// - Writing one to reset-register bit 1 empties the receive FIFO pointers.
// - That receive flush does the same as the FIFO-control receive reset bit, other settings kept.
// - Flush bits clear themselves, so the reset register never shows a pending flush.
// - Writing one to reset-register bit 0 resets the whole controller at once, released on the clock; the core asserts it one clock edge after the write.
// - The software reset reaches every clock domain of the controller.
// - Each FIFO has a depth, sixteen by default, that bounds the counts and sets the full flags.
package ufsr_pkg;
	localparam int unsigned ufsr_addr_w = 32;
	localparam int unsigned ufsr_data_w = 16;
	localparam logic [31:0] ufsr_off_status = 32'h5000117c;
	localparam logic [31:0] ufsr_off_tx_level = 32'h50001180;
	localparam logic [31:0] ufsr_off_rx_level = 32'h50001184;
	localparam logic [31:0] ufsr_off_soft_reset = 32'h50001188;
	localparam logic [31:0] ufsr_off_fifo_control = 32'h50001200;
	localparam logic [31:0] ufsr_off_irq_status = 32'h50001204;
	localparam logic [31:0] ufsr_off_irq_mask = 32'h50001208;
	localparam int unsigned ufsr_bit_rx_full = 4;
	localparam int unsigned ufsr_bit_rx_not_empty = 3;
	localparam int unsigned ufsr_bit_tx_empty = 2;
	localparam int unsigned ufsr_bit_tx_not_full = 1;
	localparam int unsigned ufsr_bit_tx_flush = 2;
	localparam int unsigned ufsr_bit_rx_flush = 1;
	localparam int unsigned ufsr_bit_soft_reset = 0;
	localparam int unsigned ufsr_bit_fifo_enable = 0;
	localparam logic [15:0] ufsr_status_reset = 16'h0006;
	localparam logic [15:0] ufsr_level_reset = 16'h0000;
	localparam logic [15:0] ufsr_status_mask = 16'h001e;
	localparam logic [15:0] ufsr_fcr_keep_mask = 16'h00f9;
	localparam int unsigned ufsr_fifo_depth = 16;
	localparam int unsigned ufsr_rst_hold = 2;
	// interrupt events: 0 rx not empty, 1 rx full, 2 tx empty, 3 tx overflow, 4 rx overflow
	localparam int unsigned ufsr_irq_w = 5;
	typedef enum logic [1:0] {
		ufsr_run_s = 2'b00,
		ufsr_hold_s = 2'b01,
		ufsr_release_s = 2'b10
	} ufsr_rst_state_t;
endpackage : ufsr_pkg

//--- tb/ufsr_peer.sv
/* serial peer model: pushes received entries while send is high and drains
   transmit entries while drain is high; assumes the bench clock */
`timescale 1ns/1ps
`default_nettype none
module ufsr_peer (
	input wire logic clock,
	input wire logic send,
	input wire logic drain,
	output logic rx_push,
	output logic tx_pop
);
	// registered, so the peer always lags the bench by one cycle
	always_ff @(posedge clock) begin
		rx_push <= send;
		tx_pop <= drain;
	end
endmodule : ufsr_peer
`default_nettype wire

//--- tb/ufsr_props.sv
/* port assertions for ufsr_core; bound to every instance of it */
`timescale 1ns/1ps
`default_nettype none
module ufsr_props import ufsr_pkg::*; #(parameter int unsigned depth = 16) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [31:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic tx_push,
	input wire logic tx_pop,
	input wire logic rx_push,
	input wire logic rx_pop,
	input wire logic tx_fifo_flush,
	input wire logic rx_fifo_flush,
	input wire logic controller_soft_reset,
	input wire logic fifo_enable,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic wsr;
	logic wfc;
	logic quiet;
	// writes landing while the soft reset runs are overridden by it
	assign quiet = !controller_soft_reset;
	assign wsr = wr && addr == ufsr_off_soft_reset;
	assign wfc = wr && addr == ufsr_off_fifo_control;
	chk_tx_flush_go: assert property (quiet && wsr && wdata[2] |=> tx_fifo_flush)
		else $error("tx flush missing");
	chk_rx_flush_go: assert property (quiet && wsr && wdata[1] |=> rx_fifo_flush)
		else $error("rx flush missing");
	chk_fcr_tx_alias: assert property (quiet && wfc && wdata[2] |=> tx_fifo_flush)
		else $error("fcr tx flush");
	chk_fcr_rx_alias: assert property (quiet && wfc && wdata[1] |=> rx_fifo_flush)
		else $error("fcr rx flush");
	chk_flush_self_clear: assert property (tx_fifo_flush && !wsr && !wfc |=> !tx_fifo_flush)
		else $error("flush stuck");
	chk_soft_reset_hold: assert property (quiet && wsr && wdata[0] |=>
		controller_soft_reset[*2] ##1 !controller_soft_reset) else $error("soft reset span");
	chk_reset_reg_read: assert property (rd && addr == ufsr_off_soft_reset |=> rdata == 16'h0000)
		else $error("reset reg read");
	chk_status_reserved: assert property (rd && addr == ufsr_off_status |=> rdata[15:5] == 11'h000 && !rdata[0])
		else $error("status reserved");
	chk_tx_level_max: assert property (rd && addr == ufsr_off_tx_level |=> rdata <= 16'(depth))
		else $error("tx level above depth");
	chk_rx_level_max: assert property (rd && addr == ufsr_off_rx_level |=> rdata <= 16'(depth))
		else $error("rx level above depth");
	chk_full_not_empty: assert property (rd && addr == ufsr_off_status |=> !rdata[4] || rdata[3])
		else $error("rx full but empty");
	chk_empty_not_full: assert property (rd && addr == ufsr_off_status |=> !rdata[2] || rdata[1])
		else $error("tx empty but full");
	cover property (tx_fifo_flush);
	cover property (controller_soft_reset);
	cover property (rd && addr == ufsr_off_status);
endmodule : ufsr_props
bind ufsr_core ufsr_props #(.depth(depth)) u_ufsr_props (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
	.tx_push, .tx_pop, .rx_push, .rx_pop, .tx_fifo_flush, .rx_fifo_flush, .controller_soft_reset, .fifo_enable, .irq);
`default_nettype wire

//--- tb/tb.sv
/* bench for ufsr_core: table of fill cases, then pops, fcr, irq and soft reset;
   the peer model feeds the receive side and drains the transmit side */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ufsr_pkg::*;
	localparam int unsigned dep = 4;
	typedef struct {int n_tx; int n_rx; logic [15:0] st;} ufsr_row_t;
	ufsr_row_t rows [4] = '{'{1, 1, 16'h000a}, '{3, 4, 16'h001a}, '{6, 6, 16'h0018}, '{0, 0, 16'h0006}};
	logic clock = 0, rst_n = 0, wr = 0, rd = 0, tx_push = 0, rx_pop = 0, send = 0, drain = 0;
	logic [31:0] addr = '0;
	logic [15:0] wdata = '0;
	logic [15:0] rdata;
	logic rx_push, tx_pop, tx_fifo_flush, rx_fifo_flush, controller_soft_reset, fifo_enable, irq;
	int err_total = 0;
	int checks_done = 0;
	always #50 clock = ~clock;
	ufsr_core #(.depth(dep)) u_ufsr_core (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .tx_push, .tx_pop,
		.rx_push, .rx_pop, .tx_fifo_flush, .rx_fifo_flush, .controller_soft_reset, .fifo_enable, .irq);
	ufsr_peer u_ufsr_peer (.clock, .send, .drain, .rx_push, .tx_pop);
	task automatic close_out();
		$display("mismatches %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic put(input logic [31:0] a, input logic [15:0] d);
		@(posedge clock);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clock);
		wr <= 0;
	endtask : put
	task automatic get(input logic [31:0] a, input logic [15:0] exp);
		@(posedge clock);
		{rd, addr} <= {1'b1, a};
		@(posedge clock);
		rd <= 0;
		#1 chk(rdata, exp);
	endtask : get
	// v is {tx_push, rx_pop, send, drain}; trailing idle lets the peer lag settle
	task automatic step(input int n, input logic [3:0] v);
		repeat (n) begin
			@(posedge clock);
			{tx_push, rx_pop, send, drain} <= v;
		end
		@(posedge clock);
		{tx_push, rx_pop, send, drain} <= 4'h0;
		repeat (2) @(posedge clock);
		// step off the edge so level outputs are read settled
		#1;
	endtask : step
	initial begin
		#200us;
		err_total++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1;
		get(ufsr_off_status, 16'h0006);
		get(ufsr_off_tx_level, 16'h0000);
		get(ufsr_off_rx_level, 16'h0000);
		foreach (rows[i]) begin
			put(ufsr_off_soft_reset, 16'h0006);
			#1 chk({14'h0, tx_fifo_flush, rx_fifo_flush}, 16'h0003);
			step(rows[i].n_tx, 4'h8);
			step(rows[i].n_rx, 4'h2);
			get(ufsr_off_status, rows[i].st);
			get(ufsr_off_tx_level, 16'(rows[i].n_tx > dep ? dep : rows[i].n_tx));
			get(ufsr_off_rx_level, 16'(rows[i].n_rx > dep ? dep : rows[i].n_rx));
		end
		get(ufsr_off_soft_reset, 16'h0000);
		step(3, 4'h8);
		step(2, 4'h1);
		get(ufsr_off_tx_level, 16'h0001);
		step(3, 4'h1);
		get(ufsr_off_tx_level, 16'h0000);
		step(2, 4'h2);
		step(1, 4'h4);
		get(ufsr_off_rx_level, 16'h0001);
		put(ufsr_off_status, 16'hffff);
		get(ufsr_off_status, 16'h000e);
		get(32'h50001300, 16'h0000);
		put(ufsr_off_fifo_control, 16'h0007);
		get(ufsr_off_fifo_control, 16'h0001);
		get(ufsr_off_rx_level, 16'h0000);
		chk({15'h0, fifo_enable}, 16'h0001);
		put(ufsr_off_irq_mask, 16'h001f);
		step(0, 4'h0);
		chk({15'h0, irq}, 16'h0001);
		put(ufsr_off_irq_status, 16'h001f);
		put(ufsr_off_irq_mask, 16'h0000);
		step(1, 4'h2);
		chk({15'h0, irq}, 16'h0000);
		put(ufsr_off_irq_mask, 16'h0001);
		step(0, 4'h0);
		chk({15'h0, irq}, 16'h0001);
		put(ufsr_off_irq_status, 16'h0001);
		step(2, 4'h8);
		chk({15'h0, irq}, 16'h0000);
		put(ufsr_off_soft_reset, 16'h0001);
		#1 chk({15'h0, controller_soft_reset}, 16'h0001);
		repeat (5) @(posedge clock);
		get(ufsr_off_tx_level, 16'h0000);
		get(ufsr_off_fifo_control, 16'h0000);
		// second hard reset in mid-run with entries pending
		step(2, 4'h8);
		@(posedge clock);
		rst_n <= 0;
		repeat (2) @(posedge clock);
		rst_n <= 1;
		get(ufsr_off_status, ufsr_status_reset);
		get(ufsr_off_tx_level, ufsr_level_reset);
		close_out();
	end
endmodule : tb
`default_nettype wire
